// File: inc/aig_regs.vh
`ifndef AIG_REGS_VH
`define AIG_REGS_VH
// Pixel component width and gain format
`define AIG_PIX_W 8
`define AIG_FULL_SCALE 8'hFF
`define AIG_GAIN_W 10
`define AIG_GAIN_FRAC 6
`define AIG_GAIN_UNITY 10'h040
`define AIG_GAIN_MAX 10'h3FF
// Histogram bins per channel (top bits of the pixel)
`define AIG_BIN_W 4
`define AIG_BINS 16
// Clip budget width (pixels allowed to saturate)
`define AIG_CLIP_W 16
`define AIG_CLIP_RST 16'h0010
// LED current command width and nominal value
`define AIG_LED_W 10
`define AIG_LED_NOM_RST 10'h200
`define AIG_LED_MIN 10'h010
// Mode blend setting width (0 = pure power cut, max = pure brightness)
`define AIG_BLEND_W 4
`define AIG_BLEND_MAX 4'hF
`endif

// File: hw/aig_gain_mult.v
`default_nettype none
`include "aig_regs.vh"
// ****************************************
// Per-channel gain multiplier with clamp
// ****************************************
module aig_gain_mult (
   input wire clk,
   input wire rst_n,
   input wire [`AIG_PIX_W-1:0] pix,
   input wire [`AIG_GAIN_W-1:0] gain,
   output reg [`AIG_PIX_W-1:0] pix_out_r
);
   wire [`AIG_PIX_W+`AIG_GAIN_W-1:0] prod;
   wire [`AIG_PIX_W+`AIG_GAIN_W-`AIG_GAIN_FRAC-1:0] scaled;
   assign prod = pix * gain;
   assign scaled = prod[`AIG_PIX_W+`AIG_GAIN_W-1:`AIG_GAIN_FRAC];
   // Saturate rather than wrap, so clipped pixels land at full scale
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_out_r <= {`AIG_PIX_W{1'b0}};
      end else if (|scaled[`AIG_PIX_W+`AIG_GAIN_W-`AIG_GAIN_FRAC-1:`AIG_PIX_W])
      begin
         pix_out_r <= `AIG_FULL_SCALE;
      end else begin
         pix_out_r <= scaled[`AIG_PIX_W-1:0];
      end
   end
endmodule
`default_nettype wire

// File: hw/aig_chan_stat.v
`default_nettype none
`include "aig_regs.vh"
// ****************************************
// Per-channel histogram and peak bin pick
// ****************************************
module aig_chan_stat (
   input wire clk,
   input wire rst_n,
   input wire pix_vld,
   input wire [`AIG_PIX_W-1:0] pix,
   input wire frame_end,
   input wire [`AIG_CLIP_W-1:0] clip_budget,
   output reg [`AIG_BIN_W-1:0] peak_bin_r,
   output reg done_r
);
   localparam ST_IDLE = 1'b0;
   localparam ST_SCAN = 1'b1;
   reg [`AIG_CLIP_W-1:0] hist_r [0:`AIG_BINS-1];
   reg state_r;
   reg [`AIG_BIN_W-1:0] idx_r;
   reg [`AIG_CLIP_W-1:0] acc_r;
   wire [`AIG_BIN_W-1:0] bin;
   wire [`AIG_CLIP_W:0] acc_sum;
   assign bin = pix[`AIG_PIX_W-1:`AIG_PIX_W-`AIG_BIN_W];
   assign acc_sum = {1'b0, acc_r} + {1'b0, hist_r[idx_r]};
   // Bins count this frame; cleared one by one during the scan
   genvar g;
   generate
      for (g = 0; g < `AIG_BINS; g = g + 1) begin : g_bin
         always @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               hist_r[g] <= {`AIG_CLIP_W{1'b0}};
            end else if (state_r == ST_SCAN && idx_r == g) begin
               hist_r[g] <= {`AIG_CLIP_W{1'b0}};
            end else if (state_r == ST_IDLE && pix_vld && bin == g &&
               hist_r[g] != {`AIG_CLIP_W{1'b1}}) begin
               hist_r[g] <= hist_r[g] + 1'b1;
            end
         end
      end
   endgenerate
   // Walk down from the top bin; the peak is the highest bin reached
   // before the clip budget is spent, so only a few pixels saturate
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         idx_r <= {`AIG_BIN_W{1'b1}};
         acc_r <= {`AIG_CLIP_W{1'b0}};
         peak_bin_r <= {`AIG_BIN_W{1'b1}};
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (frame_end) begin
                  state_r <= ST_SCAN;
                  idx_r <= {`AIG_BIN_W{1'b1}};
                  acc_r <= {`AIG_CLIP_W{1'b0}};
                  peak_bin_r <= {`AIG_BIN_W{1'b0}};
               end
            end
            default: begin
               if (acc_sum > {1'b0, clip_budget} &&
                  peak_bin_r == {`AIG_BIN_W{1'b0}} && acc_r != 0) begin
                  peak_bin_r <= idx_r;
               end else if (acc_sum > {1'b0, clip_budget} &&
                  acc_r == 0) begin
                  peak_bin_r <= idx_r;
               end
               acc_r <= acc_sum[`AIG_CLIP_W] ? {`AIG_CLIP_W{1'b1}} :
                  acc_sum[`AIG_CLIP_W-1:0];
               if (idx_r == {`AIG_BIN_W{1'b0}}) begin
                  state_r <= ST_IDLE;
                  done_r <= 1'b1;
               end else begin
                  idx_r <= idx_r - 1'b1;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: hw/aig_top.v
// Function
// - Each frame is analysed to find separate red, green, blue gains.
// - Every pixel of a channel is multiplied by that channel's frame gain.
// - Gain pushes pixels toward full scale, letting only few pixels clip.
// - A separate LED current command is issued per colour.
// - Gain and LED current per channel are chosen together.
// - Gain and LED current follow user configuration inputs.
// - Common scaling keeps the white point fixed frame to frame.
// - Power mode: LED current drops as gain rises, brightness kept.
// - Brightness mode: gains rise, LED current stays nominal.
// - A blend setting places operation between the two modes.
// - Power mode: white frame gives nominal, black frame about nominal/16 (floor 0x010).
// - Each colour LED is reduced on its own when below nominal.
`default_nettype none
`include "aig_regs.vh"
module aig_top (
   input wire clk,
   input wire rst_n,
   input wire enable,
   input wire [`AIG_BLEND_W-1:0] blend,
   input wire [`AIG_CLIP_W-1:0] clip_budget,
   input wire [`AIG_LED_W-1:0] led_nominal,
   input wire white_lock,
   input wire frame_start,
   input wire pix_vld,
   input wire [`AIG_PIX_W-1:0] pix_r_in,
   input wire [`AIG_PIX_W-1:0] pix_g_in,
   input wire [`AIG_PIX_W-1:0] pix_b_in,
   output reg out_vld_r,
   output reg out_frame_start_r,
   output wire [`AIG_PIX_W-1:0] pix_r_out,
   output wire [`AIG_PIX_W-1:0] pix_g_out,
   output wire [`AIG_PIX_W-1:0] pix_b_out,
   output reg [`AIG_LED_W-1:0] led_r_cur_r,
   output reg [`AIG_LED_W-1:0] led_g_cur_r,
   output reg [`AIG_LED_W-1:0] led_b_cur_r,
   output reg led_update_r,
   output reg [`AIG_GAIN_W-1:0] gain_r_r,
   output reg [`AIG_GAIN_W-1:0] gain_g_r,
   output reg [`AIG_GAIN_W-1:0] gain_b_r
);
   // ****************************************
   // Frame tracking and statistics
   // ****************************************
   reg seen_frame_r;
   wire frame_end;
   wire [`AIG_BIN_W-1:0] peak_r, peak_g, peak_b;
   wire done_r_c, done_g_c, done_b_c;
   // A frame ends when the next one starts; first start has no stats
   assign frame_end = frame_start & seen_frame_r;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_frame_r <= 1'b0;
      end else if (frame_start) begin
         seen_frame_r <= 1'b1;
      end
   end
   aig_chan_stat u_stat_r (
      .clk(clk), .rst_n(rst_n), .pix_vld(pix_vld), .pix(pix_r_in),
      .frame_end(frame_end), .clip_budget(clip_budget),
      .peak_bin_r(peak_r), .done_r(done_r_c));
   aig_chan_stat u_stat_g (
      .clk(clk), .rst_n(rst_n), .pix_vld(pix_vld), .pix(pix_g_in),
      .frame_end(frame_end), .clip_budget(clip_budget),
      .peak_bin_r(peak_g), .done_r(done_g_c));
   aig_chan_stat u_stat_b (
      .clk(clk), .rst_n(rst_n), .pix_vld(pix_vld), .pix(pix_b_in),
      .frame_end(frame_end), .clip_budget(clip_budget),
      .peak_bin_r(peak_b), .done_r(done_b_c));

   // ****************************************
   // Joint gain and LED decision
   // ****************************************
   // Raw gain = full scale / top of peak bin, as 4.6 fixed point
   function [`AIG_GAIN_W-1:0] raw_gain;
      input [`AIG_BIN_W-1:0] pk;
      reg [15:0] num;
      reg [15:0] q;
      begin
         num = 16'h3FC0; // 255 << 6
         q = num / ({12'h000, pk} * 16'h0010 + 16'h0010);
         // Never dim below unity: a full-scale channel would otherwise ask
         // for more than nominal LED current to keep its brightness
         if (q < {6'h00, `AIG_GAIN_UNITY}) begin
            raw_gain = `AIG_GAIN_UNITY;
         end else if (q > 16'h03FF) begin
            raw_gain = `AIG_GAIN_MAX;
         end else begin
            raw_gain = q[`AIG_GAIN_W-1:0];
         end
      end
   endfunction
   // LED share = nominal / gain, blended toward nominal by setting
   function [`AIG_LED_W-1:0] led_pick;
      input [`AIG_GAIN_W-1:0] g;
      input [`AIG_LED_W-1:0] nom;
      input [`AIG_BLEND_W-1:0] bl;
      reg [19:0] pw;
      reg [19:0] mix;
      begin
         pw = ({10'h000, nom} << `AIG_GAIN_FRAC) / {10'h000, g};
         mix = (pw * {16'h0000, `AIG_BLEND_MAX - bl} +
            {10'h000, nom} * {16'h0000, bl}) / 20'h0000F;
         if (mix < {10'h000, `AIG_LED_MIN}) begin
            led_pick = `AIG_LED_MIN;
         end else begin
            led_pick = mix[`AIG_LED_W-1:0];
         end
      end
   endfunction
   wire [`AIG_GAIN_W-1:0] rg_r, rg_g, rg_b, rg_min, gr_n, gg_n, gb_n;
   assign rg_r = raw_gain(peak_r);
   assign rg_g = raw_gain(peak_g);
   assign rg_b = raw_gain(peak_b);
   assign rg_min = (rg_r < rg_g) ? ((rg_r < rg_b) ? rg_r : rg_b) :
      ((rg_g < rg_b) ? rg_g : rg_b);
   // White lock uses one common gain so colour ratios do not drift
   assign gr_n = white_lock ? rg_min : rg_r;
   assign gg_n = white_lock ? rg_min : rg_g;
   assign gb_n = white_lock ? rg_min : rg_b;
   reg [`AIG_GAIN_W-1:0] pend_gr_r, pend_gg_r, pend_gb_r;
   reg [`AIG_LED_W-1:0] pend_lr_r, pend_lg_r, pend_lb_r;
   reg pend_r;
   // Gain and LED are latched together from the same analysis result
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
         pend_gr_r <= `AIG_GAIN_UNITY;
         pend_gg_r <= `AIG_GAIN_UNITY;
         pend_gb_r <= `AIG_GAIN_UNITY;
         pend_lr_r <= `AIG_LED_NOM_RST;
         pend_lg_r <= `AIG_LED_NOM_RST;
         pend_lb_r <= `AIG_LED_NOM_RST;
      end else if (done_r_c & done_g_c & done_b_c) begin
         pend_r <= 1'b1;
         if (enable) begin
            pend_gr_r <= gr_n;
            pend_gg_r <= gg_n;
            pend_gb_r <= gb_n;
            pend_lr_r <= led_pick(gr_n, led_nominal, blend);
            pend_lg_r <= led_pick(gg_n, led_nominal, blend);
            pend_lb_r <= led_pick(gb_n, led_nominal, blend);
         end else begin
            pend_gr_r <= `AIG_GAIN_UNITY;
            pend_gg_r <= `AIG_GAIN_UNITY;
            pend_gb_r <= `AIG_GAIN_UNITY;
            pend_lr_r <= led_nominal;
            pend_lg_r <= led_nominal;
            pend_lb_r <= led_nominal;
         end
      end else if (frame_start) begin
         pend_r <= 1'b0;
      end
   end

   // ****************************************
   // Frame-boundary commit
   // ****************************************
   // Scan takes 16 cycles, so results commit at the following frame
   // start; no frame ever mixes old and new settings
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_r_r <= `AIG_GAIN_UNITY;
         gain_g_r <= `AIG_GAIN_UNITY;
         gain_b_r <= `AIG_GAIN_UNITY;
         led_r_cur_r <= `AIG_LED_NOM_RST;
         led_g_cur_r <= `AIG_LED_NOM_RST;
         led_b_cur_r <= `AIG_LED_NOM_RST;
         led_update_r <= 1'b0;
      end else begin
         led_update_r <= 1'b0;
         if (frame_start && pend_r) begin
            gain_r_r <= pend_gr_r;
            gain_g_r <= pend_gg_r;
            gain_b_r <= pend_gb_r;
            led_r_cur_r <= pend_lr_r;
            led_g_cur_r <= pend_lg_r;
            led_b_cur_r <= pend_lb_r;
            led_update_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Pixel path
   // ****************************************
   // Gain regs change on frame_start; pixels of that cycle use old gain,
   // so the frame's first pixel must follow frame_start by a cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_vld_r <= 1'b0;
         out_frame_start_r <= 1'b0;
      end else begin
         out_vld_r <= pix_vld;
         out_frame_start_r <= frame_start;
      end
   end
   aig_gain_mult u_mul_r (.clk(clk), .rst_n(rst_n), .pix(pix_r_in),
      .gain(gain_r_r), .pix_out_r(pix_r_out));
   aig_gain_mult u_mul_g (.clk(clk), .rst_n(rst_n), .pix(pix_g_in),
      .gain(gain_g_r), .pix_out_r(pix_g_out));
   aig_gain_mult u_mul_b (.clk(clk), .rst_n(rst_n), .pix(pix_b_in),
      .gain(gain_b_r), .pix_out_r(pix_b_out));
endmodule
`default_nettype wire

// File: bench/aig_props.sv
`default_nettype none
module aig_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [3:0] blend,
   input wire logic [9:0] led_nominal,
   input wire logic white_lock,
   input wire logic frame_start,
   input wire logic pix_vld,
   input wire logic [7:0] pix_r_in,
   input wire logic [7:0] pix_g_in,
   input wire logic [7:0] pix_b_in,
   input wire logic out_vld_r,
   input wire logic out_frame_start_r,
   input wire logic [7:0] pix_r_out,
   input wire logic [7:0] pix_g_out,
   input wire logic [7:0] pix_b_out,
   input wire logic [9:0] led_r_cur_r,
   input wire logic [9:0] led_g_cur_r,
   input wire logic [9:0] led_b_cur_r,
   input wire logic led_update_r,
   input wire logic [9:0] gain_r_r,
   input wire logic [9:0] gain_g_r,
   input wire logic [9:0] gain_b_r
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Helpers
   // ****************************************
   // Settings age: pins are live, so outputs may follow them a cycle late
   logic [15:0] cfg_q;
   logic [1:0] age_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q <= 16'h0000;
         age_r <= 2'd0;
      end else begin
         cfg_q <= {enable, blend, white_lock, led_nominal};
         if (cfg_q != {enable, blend, white_lock, led_nominal})
            age_r <= 2'd0;
         else if (age_r != 2'd3)
            age_r <= age_r + 2'd1;
      end
   end
   // Gain product with saturation at full scale
   function automatic logic [7:0] sat(input logic [7:0] p,
      input logic [9:0] g);
      logic [17:0] m;
      m = ({10'h000, p} * {8'h00, g}) >> 6;
      return (m > 18'h0_00FF) ? 8'hFF : m[7:0];
   endfunction
   // ****************************************
   // Properties
   // ****************************************
   chk_gain_on_frame: assert property (
      !$stable({gain_r_r, gain_g_r, gain_b_r}) && age_r == 2'd3
      |-> $past(frame_start)) else $error("gain moved off frame");
   chk_led_on_frame: assert property (
      !$stable({led_r_cur_r, led_g_cur_r, led_b_cur_r}) && age_r == 2'd3
      |-> $past(frame_start)) else $error("led moved off frame");
   chk_start_delay: assert property (
      frame_start |=> out_frame_start_r) else $error("frame start lost");
   chk_update_after: assert property (
      led_update_r |-> $past(frame_start)) else $error("stray update");
   chk_pixel_gain: assert property (
      pix_vld |=> out_vld_r
      && pix_r_out == sat($past(pix_r_in), $past(gain_r_r))
      && pix_g_out == sat($past(pix_g_in), $past(gain_g_r))
      && pix_b_out == sat($past(pix_b_in), $past(gain_b_r)))
      else $error("pixel product wrong");
   chk_white_lock: assert property (
      white_lock && enable && age_r == 2'd3 && led_update_r
      |-> gain_r_r == gain_g_r && gain_g_r == gain_b_r)
      else $error("locked gains differ");
   chk_bright_nominal: assert property (
      enable && blend == 4'hF && age_r == 2'd3 && led_update_r
      |-> led_r_cur_r == led_nominal && led_g_cur_r == led_nominal
      && led_b_cur_r == led_nominal) else $error("bright led off");
   chk_led_floor: assert property (
      enable && led_update_r |-> led_r_cur_r >= 10'h010
      && led_g_cur_r >= 10'h010 && led_b_cur_r >= 10'h010)
      else $error("led below floor");
   chk_off_unity: assert property (
      !enable && age_r == 2'd3 && led_update_r |-> gain_r_r == 10'h040
      && led_r_cur_r == led_nominal) else $error("bypass not unity");
   cover property (enable && blend == 4'h0 && led_update_r);
   cover property (white_lock && led_update_r);
   cover property (!enable && led_update_r);
endmodule
bind aig_top aig_props u_aig_props (.*);
`default_nettype wire

// File: bench/aig_src_model.sv
`default_nettype none
module aig_src_model (
   input wire logic clk,
   output logic frame_start,
   output logic pix_vld,
   output logic [7:0] pix_r_in,
   output logic [7:0] pix_g_in,
   output logic [7:0] pix_b_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Pixel pipeline source
   // ****************************************
   initial begin
      frame_start = 1'b0;
      pix_vld = 1'b0;
      {pix_r_in, pix_g_in, pix_b_in} = 24'h00_0000;
   end
   // Idle lanes toggle so stale data can never pass for a pixel
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk);
         frame_start = 1'b0;
         pix_vld = 1'b0;
         {pix_r_in, pix_g_in, pix_b_in} = ~{pix_r_in, pix_g_in, pix_b_in};
      end
   endtask
   task automatic pixel(input logic [7:0] r, g, b);
      @(negedge clk);
      frame_start = 1'b0;
      pix_vld = 1'b1;
      {pix_r_in, pix_g_in, pix_b_in} = {r, g, b};
   endtask
   // Pixels wait out the 16-cycle scan, else they would not be counted
   task automatic frame(input logic [7:0] r, g, b);
      @(negedge clk);
      frame_start = 1'b1;
      pix_vld = 1'b0;
      idle(20);
      repeat (16) pixel(r, g, b);
      idle(2);
   endtask
endmodule
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable = 1'b1;
   logic [3:0] blend = 4'h0;
   logic [15:0] clip_budget = 16'h0004;
   logic [9:0] led_nominal = 10'h0200;
   logic white_lock = 1'b0;
   wire logic frame_start, pix_vld, out_vld_r, out_frame_start_r;
   wire logic led_update_r;
   wire logic [7:0] pix_r_in, pix_g_in, pix_b_in;
   wire logic [7:0] pix_r_out, pix_g_out, pix_b_out;
   wire logic [9:0] led_r_cur_r, led_g_cur_r, led_b_cur_r;
   wire logic [9:0] gain_r_r, gain_g_r, gain_b_r;
   int fails = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   aig_top u_aig_top (.*);
   aig_src_model u_aig_src_model (.*);
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [9:0] exp, got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Third frame start commits what the first frame measured
   task automatic settle();
      repeat (3) u_aig_src_model.frame(8'h60, 8'hF0, 8'h20);
   endtask
   task automatic pix_chk(input logic [7:0] i, r, g, b);
      u_aig_src_model.pixel(i, 8'hF0, 8'h20);
      u_aig_src_model.idle(1);
      chk("out_vld", 10'h001, {9'h000, out_vld_r});
      chk("pix_r", {2'b00, r}, {2'b00, pix_r_out});
      chk("pix_g", {2'b00, g}, {2'b00, pix_g_out});
      chk("pix_b", {2'b00, b}, {2'b00, pix_b_out});
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      chk("gain_r", 10'h040, gain_r_r);
      chk("led_r", 10'h200, led_r_cur_r);
      $display("test reset done");
   endtask
   task automatic t_power();
      settle();
      chk("gain_r", 10'h091, gain_r_r);
      chk("gain_g", 10'h040, gain_g_r);
      chk("gain_b", 10'h154, gain_b_r);
      chk("led_r_cut", 10'h001, {9'h000, led_r_cur_r < 10'h200});
      chk("led_b_cut", 10'h001, {9'h000, led_b_cur_r < led_r_cur_r});
      chk("led_own", 10'h001, {9'h000, led_g_cur_r > led_r_cur_r});
      pix_chk(8'h60, 8'hD9, 8'hF0, 8'hAA);
      $display("test power done");
   endtask
   task automatic t_bright();
      @(negedge clk);
      blend = 4'hF;
      led_nominal = 10'h180;
      settle();
      chk("gain_r", 10'h091, gain_r_r);
      chk("led_r", 10'h180, led_r_cur_r);
      chk("led_g", 10'h180, led_g_cur_r);
      chk("led_b", 10'h180, led_b_cur_r);
      $display("test bright done");
   endtask
   task automatic t_lock();
      @(negedge clk);
      white_lock = 1'b1;
      settle();
      chk("gain_r", 10'h040, gain_r_r);
      chk("gain_b", 10'h040, gain_b_r);
      chk("led_b", 10'h180, led_b_cur_r);
      $display("test lock done");
   endtask
   task automatic t_off();
      @(negedge clk);
      enable = 1'b0;
      white_lock = 1'b0;
      settle();
      chk("gain_g", 10'h040, gain_g_r);
      chk("led_g", 10'h180, led_g_cur_r);
      pix_chk(8'h60, 8'h60, 8'hF0, 8'h20);
      $display("test off done");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_power();
      t_bright();
      t_lock();
      t_off();
      conclude();
   end
   // Watchdog: the tests need about 480 cycles, so this is ample
   initial begin
      repeat (4000) @(posedge clk);
      fails++;
      conclude();
   end
endmodule
`default_nettype wire
